/* File: iep_defs.svh */
`ifndef IEP_DEFS_SVH
`define IEP_DEFS_SVH

// Register indices; byte offset is index times four
`define IEP_IDX_EN1      4'h0
`define IEP_IDX_EN3      4'h1
`define IEP_IDX_EN4      4'h2
`define IEP_IDX_PRI0     4'h3
`define IEP_IDX_PRI1     4'h4
`define IEP_IDX_PRI2     4'h5
`define IEP_IDX_PRI3     4'h6
`define IEP_IDX_PRI4     4'h7
`define IEP_IDX_MASK     4'h8
`define IEP_IDX_STATUS   4'h9
`define IEP_IDX_PRESENT  4'hA
`define IEP_NUM_RW       9
`define IEP_NUM_SRC      13

// Implemented-bit masks
`define IEP_MASK_EN1     16'h20DB
`define IEP_MASK_EN3     16'h8600
`define IEP_MASK_EN4     16'h0602
`define IEP_MASK_PRI0    16'h7777
`define IEP_MASK_PRI1    16'h7770
`define IEP_MASK_PRI2    16'h7777
`define IEP_MASK_PRI3    16'h0077
`define IEP_MASK_PRI4    16'h7077
`define IEP_MASK_SRC     16'h1FFF

// Reset values: every priority field at level 4
`define IEP_RST_PRI0     16'h4444
`define IEP_RST_PRI1     16'h4440
`define IEP_RST_PRI2     16'h4444
`define IEP_RST_PRI3     16'h0044
`define IEP_RST_PRI4     16'h4044
`define IEP_RST_ZERO     16'h0000

// Enable bit positions
`define IEP_EN1_EXT2     13
`define IEP_EN1_CAP8     7
`define IEP_EN1_CAP7     6
`define IEP_EN1_EXT1     4
`define IEP_EN1_CN       3
`define IEP_EN1_I2CM     1
`define IEP_EN1_I2CS     0
`define IEP_EN3_PWMAFLT  15
`define IEP_EN3_QEI      10
`define IEP_EN3_PWMAERR  9
`define IEP_EN4_PWMBFLT  10
`define IEP_EN4_PWMBERR  9
`define IEP_EN4_UARTERR  1

// Priority field lsb positions in priority register four
`define IEP_PRI4_CN      12
`define IEP_PRI4_I2CM    4
`define IEP_PRI4_I2CS    0

// Source indices; only CN, I2CM and I2CS have a local priority field
`define IEP_SRC_CN       2
`define IEP_SRC_I2CM     1
`define IEP_SRC_I2CS     0
`define IEP_SRC_PWMBFLT  12
`define IEP_SRC_PWMAFLT  9
`define IEP_SRC_EXT2     6

`endif

/* File: iep_irq_enable_priority_bank.sv */
// Local design decisions: the Wishbone interface to the registers and the register offsets.
`timescale 1ns/100ps
`include "iep_defs.svh"
module iep_irq_enable_priority_bank (
  input  wire logic                  core_clk,
  input  wire logic                  rst,
  input  wire logic                  ce,
  input  wire logic                  wbCycI,
  input  wire logic                  wbStbI,
  input  wire logic                  wbWeI,
  input  wire logic [7:0]            wbAdrI,
  input  wire logic [3:0]            wbSelI,
  input  wire logic [31:0]           wbDatI,
  output logic      [31:0]           wbDatO,
  output logic                       wbAckO,
  input  wire logic [12:0]           srcReq,
  output logic      [12:0]           srcPresent,
  output logic      [79:0]           prioWords,
  output logic                       irqOut
);

  iep_pkg::iep_word_t regs_reg [0:`IEP_NUM_RW-1];
  logic [12:0]        status_reg;
  logic [12:0]        present_reg;
  logic [31:0]        rdat_reg;
  logic               ack_reg;
  logic               irq_reg;
  logic               take;
  iep_pkg::iep_idx_t  idx;
  iep_pkg::iep_word_t lane;
  logic [12:0]        enVec;
  logic [12:0]        prioOk;
  logic [12:0]        present_next;
  logic [12:0]        status_next;
  logic               statusRead;

  function automatic iep_pkg::iep_word_t regMask(input iep_pkg::iep_idx_t i);
    case (i)
      `IEP_IDX_EN1:  regMask = `IEP_MASK_EN1;
      `IEP_IDX_EN3:  regMask = `IEP_MASK_EN3;
      `IEP_IDX_EN4:  regMask = `IEP_MASK_EN4;
      `IEP_IDX_PRI0: regMask = `IEP_MASK_PRI0;
      `IEP_IDX_PRI1: regMask = `IEP_MASK_PRI1;
      `IEP_IDX_PRI2: regMask = `IEP_MASK_PRI2;
      `IEP_IDX_PRI3: regMask = `IEP_MASK_PRI3;
      `IEP_IDX_PRI4: regMask = `IEP_MASK_PRI4;
      `IEP_IDX_MASK: regMask = `IEP_MASK_SRC;
      default:       regMask = `IEP_RST_ZERO;
    endcase
  endfunction : regMask

  function automatic iep_pkg::iep_word_t regReset(input iep_pkg::iep_idx_t i);
    case (i)
      `IEP_IDX_PRI0: regReset = `IEP_RST_PRI0;
      `IEP_IDX_PRI1: regReset = `IEP_RST_PRI1;
      `IEP_IDX_PRI2: regReset = `IEP_RST_PRI2;
      `IEP_IDX_PRI3: regReset = `IEP_RST_PRI3;
      `IEP_IDX_PRI4: regReset = `IEP_RST_PRI4;
      default:       regReset = `IEP_RST_ZERO;
    endcase
  endfunction : regReset

  function automatic logic prioLive(input iep_pkg::iep_prio_t p);
    prioLive = (p != 3'h0);
  endfunction : prioLive

  assign take       = wbCycI & wbStbI & ~ack_reg;
  assign idx        = wbAdrI[5:2];
  assign lane       = {{8{wbSelI[1]}}, {8{wbSelI[0]}}};
  assign statusRead = ce & take & ~wbWeI & (wbAdrI[7:6] == 2'h0) & (idx == `IEP_IDX_STATUS);

  // Flat source order used by status, mask and present
  always_comb begin
    enVec = {regs_reg[`IEP_IDX_EN4][`IEP_EN4_PWMBFLT],
             regs_reg[`IEP_IDX_EN4][`IEP_EN4_PWMBERR],
             regs_reg[`IEP_IDX_EN4][`IEP_EN4_UARTERR],
             regs_reg[`IEP_IDX_EN3][`IEP_EN3_PWMAFLT],
             regs_reg[`IEP_IDX_EN3][`IEP_EN3_QEI],
             regs_reg[`IEP_IDX_EN3][`IEP_EN3_PWMAERR],
             regs_reg[`IEP_IDX_EN1][`IEP_EN1_EXT2],
             regs_reg[`IEP_IDX_EN1][`IEP_EN1_CAP8],
             regs_reg[`IEP_IDX_EN1][`IEP_EN1_CAP7],
             regs_reg[`IEP_IDX_EN1][`IEP_EN1_EXT1],
             regs_reg[`IEP_IDX_EN1][`IEP_EN1_CN],
             regs_reg[`IEP_IDX_EN1][`IEP_EN1_I2CM],
             regs_reg[`IEP_IDX_EN1][`IEP_EN1_I2CS]};
  end

  // Sources whose priority lives elsewhere are passed on the enable alone
  always_comb begin
    prioOk = '1;
    prioOk[`IEP_SRC_CN]   = prioLive(regs_reg[`IEP_IDX_PRI4][`IEP_PRI4_CN +: 3]);
    prioOk[`IEP_SRC_I2CM] = prioLive(regs_reg[`IEP_IDX_PRI4][`IEP_PRI4_I2CM +: 3]);
    prioOk[`IEP_SRC_I2CS] = prioLive(regs_reg[`IEP_IDX_PRI4][`IEP_PRI4_I2CS +: 3]);
  end

  assign present_next = status_reg & enVec & prioOk;

  // Set wins over the read-clear so a request in the read cycle survives
  always_comb begin
    status_next = status_reg;
    if (statusRead) begin
      status_next = '0;
    end
    status_next = status_next | srcReq;
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      for (int i = 0; i < `IEP_NUM_RW; i++) begin
        regs_reg[i] <= regReset(iep_pkg::iep_idx_t'(i));
      end
    end else if (ce && take && wbWeI && wbAdrI[7:6] == 2'h0 && idx <= `IEP_IDX_MASK) begin
      // Masked store keeps unassigned bits at zero; status and present are not storage
      regs_reg[idx] <= ((regs_reg[idx] & ~lane) | (wbDatI[15:0] & lane))
                       & regMask(idx);
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      status_reg <= '0;
    end else if (ce) begin
      status_reg <= status_next;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      present_reg <= '0;
      irq_reg     <= 1'b0;
    end else if (ce) begin
      present_reg <= present_next;
      irq_reg     <= |(status_next & regs_reg[`IEP_IDX_MASK][12:0]);
    end
  end

  // One wait state: ack follows the request edge and drops the next cycle
  always_ff @(posedge core_clk) begin
    if (rst) begin
      ack_reg  <= 1'b0;
      rdat_reg <= '0;
    end else if (ce) begin
      ack_reg <= take;
      if (take && !wbWeI) begin
        rdat_reg <= '0;
        if (wbAdrI[7:6] == 2'h0) begin
          if (idx <= `IEP_IDX_MASK) begin
            rdat_reg[15:0] <= regs_reg[idx];
          end else if (idx == `IEP_IDX_STATUS) begin
            rdat_reg[12:0] <= status_reg;
          end else if (idx == `IEP_IDX_PRESENT) begin
            rdat_reg[12:0] <= present_reg;
          end
        end
      end
    end
  end

  assign wbAckO     = ack_reg;
  assign wbDatO     = rdat_reg;
  assign srcPresent = present_reg;
  assign irqOut     = irq_reg;
  // Field layouts fixed by the masks above
  assign prioWords  = {regs_reg[`IEP_IDX_PRI4], regs_reg[`IEP_IDX_PRI3],
                       regs_reg[`IEP_IDX_PRI2], regs_reg[`IEP_IDX_PRI1],
                       regs_reg[`IEP_IDX_PRI0]};

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  property p_present_gate;
    ce |=> srcPresent == $past(status_reg & enVec & prioOk);
  endproperty
  a_present_gate: assert property (p_present_gate) else $error("present not gated");

  property p_cn_prio_zero;
    (ce && regs_reg[`IEP_IDX_PRI4][`IEP_PRI4_CN +: 3] == 3'h0) |=> !srcPresent[`IEP_SRC_CN];
  endproperty
  a_cn_prio_zero: assert property (p_cn_prio_zero) else $error("zero priority present");

  property p_i2cm_prio_zero;
    (ce && regs_reg[`IEP_IDX_PRI4][`IEP_PRI4_I2CM +: 3] == 3'h0) |=> !srcPresent[`IEP_SRC_I2CM];
  endproperty
  a_i2cm_prio_zero: assert property (p_i2cm_prio_zero) else $error("zero priority present");

  property p_i2cs_prio_zero;
    (ce && regs_reg[`IEP_IDX_PRI4][`IEP_PRI4_I2CS +: 3] == 3'h0) |=> !srcPresent[`IEP_SRC_I2CS];
  endproperty
  a_i2cs_prio_zero: assert property (p_i2cs_prio_zero) else $error("zero priority present");

  property p_en_masked;
    (regs_reg[`IEP_IDX_EN1] & ~`IEP_MASK_EN1) == 16'h0000 &&
    (regs_reg[`IEP_IDX_EN3] & ~`IEP_MASK_EN3) == 16'h0000 &&
    (regs_reg[`IEP_IDX_EN4] & ~`IEP_MASK_EN4) == 16'h0000;
  endproperty
  a_en_masked: assert property (p_en_masked) else $error("unassigned enable bit set");

  property p_pri_masked;
    (regs_reg[`IEP_IDX_PRI0] & ~`IEP_MASK_PRI0) == 16'h0000 &&
    (regs_reg[`IEP_IDX_PRI4] & ~`IEP_MASK_PRI4) == 16'h0000;
  endproperty
  a_pri_masked: assert property (p_pri_masked) else $error("unassigned priority bit set");

  property p_flag_set;
    (ce && srcReq != 13'h0) |=> (status_reg & $past(srcReq)) == $past(srcReq);
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("request not flagged");

  // A frozen ack legally stands, so only a running clock enable is checked
  property p_ack_one;
    (ce && wbAckO) |=> !wbAckO;
  endproperty
  a_ack_one: assert property (p_ack_one) else $error("ack held two cycles");

  property p_ack_follows;
    (ce && wbCycI && wbStbI && !wbAckO) |=> wbAckO;
  endproperty
  a_ack_follows: assert property (p_ack_follows) else $error("missing ack");

  // Checked on the first edge after release, so the reset itself must not disable it
  property p_reset_prio;
    @(posedge core_clk) disable iff (1'b0)
    $fell(rst) |-> regs_reg[`IEP_IDX_PRI2] == `IEP_RST_PRI2 &&
                   regs_reg[`IEP_IDX_EN1] == 16'h0000 &&
                   status_reg == 13'h0000 && present_reg == 13'h0000;
  endproperty
  a_reset_prio: assert property (p_reset_prio) else $error("bad reset");

  property p_irq;
    ce |=> irqOut == |($past(status_next) & $past(regs_reg[`IEP_IDX_MASK][12:0]));
  endproperty
  a_irq: assert property (p_irq) else $error("irq level wrong");

  property p_freeze;
    !ce |=> $stable(status_reg) && $stable(present_reg);
  endproperty
  a_freeze: assert property (p_freeze) else $error("state moved while frozen");

  // Read-clear keeps only what is requested in the read cycle itself
  property p_rdclr;
    statusRead |=> status_reg == $past(srcReq);
  endproperty
  a_rdclr: assert property (p_rdclr) else $error("status not cleared by read");

  property p_status_data;
    statusRead |=> wbDatO == {19'h00000, $past(status_reg)};
  endproperty
  a_status_data: assert property (p_status_data) else $error("status read data wrong");

  property p_unmapped_zero;
    (ce && wbCycI && wbStbI && !wbAckO && !wbWeI &&
     (wbAdrI[7:6] != 2'h0 || wbAdrI[5:2] > `IEP_IDX_PRESENT)) |=> wbDatO == 32'h00000000;
  endproperty
  a_unmapped_zero: assert property (p_unmapped_zero) else $error("unmapped read not zero");

  property p_upper_zero;
    wbDatO[31:16] == 16'h0000;
  endproperty
  a_upper_zero: assert property (p_upper_zero) else $error("upper read half not zero");

  property p_pri2_masked;
    (regs_reg[`IEP_IDX_PRI2] & ~`IEP_MASK_PRI2) == 16'h0000;
  endproperty
  a_pri2_masked: assert property (p_pri2_masked) else $error("unassigned priority bit set");

  property p_pri13_masked;
    (regs_reg[`IEP_IDX_PRI1] & ~`IEP_MASK_PRI1) == 16'h0000 &&
    (regs_reg[`IEP_IDX_PRI3] & ~`IEP_MASK_PRI3) == 16'h0000;
  endproperty
  a_pri13_masked: assert property (p_pri13_masked) else $error("unassigned priority bit set");

  // Bit positions are checked through the source order, not the enable word
  property p_en1_gate;
    (ce && !regs_reg[`IEP_IDX_EN1][`IEP_EN1_EXT2]) |=> !srcPresent[`IEP_SRC_EXT2];
  endproperty
  a_en1_gate: assert property (p_en1_gate) else $error("enable one leaks");

  property p_en3_gate;
    (ce && !regs_reg[`IEP_IDX_EN3][`IEP_EN3_PWMAFLT]) |=> !srcPresent[`IEP_SRC_PWMAFLT];
  endproperty
  a_en3_gate: assert property (p_en3_gate) else $error("enable three leaks");

  property p_en4_gate;
    (ce && !regs_reg[`IEP_IDX_EN4][`IEP_EN4_PWMBFLT]) |=> !srcPresent[`IEP_SRC_PWMBFLT];
  endproperty
  a_en4_gate: assert property (p_en4_gate) else $error("enable four leaks");

  c_present: cover property (ce && srcPresent != 13'h0);
  c_irq:     cover property ($rose(irqOut));
  c_rdclr:   cover property (statusRead && srcReq != 13'h0);
  c_freeze:  cover property (!ce && srcReq != 13'h0);
  c_prioOff: cover property (status_reg[`IEP_SRC_CN] && regs_reg[`IEP_IDX_PRI4][`IEP_PRI4_CN +: 3] == 3'h0);

endmodule : iep_irq_enable_priority_bank

/* File: iep_irq_enable_priority_bank_test.sv */
`timescale 1ns/100ps
`include "iep_defs.svh"
module iep_irq_enable_priority_bank_test;
  logic        core_clk;
  logic        rst;
  logic        ce;
  logic        cyc;
  logic        stb;
  logic        we;
  logic [7:0]  adr;
  logic [31:0] dat;
  logic [31:0] datO;
  logic        ack;
  logic [12:0] raiseCmd;
  logic [12:0] srcReq;
  logic [12:0] srcPresent;
  logic [79:0] prioWords;
  logic        irqOut;
  logic [15:0] q;
  int          num_errors;
  int          num_checks;
  iep_pkg::iep_word_t rstv [9] = '{`IEP_RST_ZERO, `IEP_RST_ZERO, `IEP_RST_ZERO, `IEP_RST_PRI0,
    `IEP_RST_PRI1, `IEP_RST_PRI2, `IEP_RST_PRI3, `IEP_RST_PRI4, `IEP_RST_ZERO};
  iep_pkg::iep_word_t mskv [9] = '{`IEP_MASK_EN1, `IEP_MASK_EN3, `IEP_MASK_EN4, `IEP_MASK_PRI0,
    `IEP_MASK_PRI1, `IEP_MASK_PRI2, `IEP_MASK_PRI3, `IEP_MASK_PRI4, `IEP_MASK_SRC};

  iep_irq_enable_priority_bank u_dut (.core_clk(core_clk), .rst(rst), .ce(ce),
    .wbCycI(cyc), .wbStbI(stb), .wbWeI(we), .wbAdrI(adr), .wbSelI(4'h3), .wbDatI(dat),
    .wbDatO(datO), .wbAckO(ack), .srcReq(srcReq), .srcPresent(srcPresent),
    .prioWords(prioWords), .irqOut(irqOut));
  iep_src_model u_src (.core_clk(core_clk), .rst(rst), .raiseCmd(raiseCmd), .srcReq(srcReq));

  task automatic summarize;
    $display("checks %0d mismatches %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : summarize

  task automatic chk(input logic [79:0] got, input logic [79:0] exp);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Classic cycle; the bus is idle for one edge before every request
  task automatic wb(input logic w, input logic [7:0] a, input logic [15:0] d);
    int n;
    n = 0;
    @(posedge core_clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w;
    adr <= a;
    dat <= {16'h0000, d};
    do begin
      @(posedge core_clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    q = datO[15:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    if (n >= 20) begin
      num_errors++;
      summarize();
    end
  endtask : wb

  // Request to present takes three edges; two more keep the look off the launching edge
  task automatic settle;
    repeat (5) @(posedge core_clk);
  endtask : settle

  task automatic test_reset;
    for (int i = 0; i < 9; i++) begin
      wb(1'b0, 8'(i * 4), 16'h0000);
      chk(q, rstv[i]);
    end
    chk(srcPresent, 13'h0000);
    $display("reset values done");
  endtask : test_reset

  task automatic test_map;
    for (int i = 0; i < 9; i++) begin
      wb(1'b1, 8'(i * 4), 16'hFFFF);
      wb(1'b0, 8'(i * 4), 16'h0000);
      chk(q, mskv[i]);
    end
    chk(prioWords, {`IEP_MASK_PRI4, `IEP_MASK_PRI3, `IEP_MASK_PRI2, `IEP_MASK_PRI1,
      `IEP_MASK_PRI0});
    wb(1'b1, 8'h30, 16'hFFFF);
    wb(1'b0, 8'h30, 16'h0000);
    chk(q, 16'h0000);
    $display("bit map done");
  endtask : test_map

  task automatic test_src;
    wb(1'b1, 8'h00, 16'hFFFF);
    wb(1'b1, 8'h08, 16'hFFFF);
    wb(1'b1, 8'h20, 16'h1FFF);
    @(posedge core_clk);
    raiseCmd <= 13'h1005;
    settle();
    chk(srcPresent, 13'h1005);
    chk(irqOut, 1'b1);
    // Zero priority on change notify and i2c slave hides both live requests
    wb(1'b1, 8'h1C, 16'h0070);
    settle();
    chk(srcPresent, 13'h1000);
    wb(1'b1, 8'h08, 16'h0000);
    settle();
    chk(srcPresent, 13'h0000);
    wb(1'b1, 8'h20, 16'h0000);
    settle();
    chk(irqOut, 1'b0);
    raiseCmd <= 13'h0000;
    settle();
    // Status is sticky, so the requests still show after they are gone
    wb(1'b0, 8'h24, 16'h0000);
    chk(q, 16'h1005);
    wb(1'b0, 8'h24, 16'h0000);
    chk(q, 16'h0000);
    $display("source path done");
  endtask : test_src

  task automatic test_freeze;
    wb(1'b1, 8'h20, 16'h1FFF);
    @(posedge core_clk);
    ce <= 1'b0;
    raiseCmd <= 13'h0008;
    settle();
    chk(srcPresent, 13'h0000);
    chk(irqOut, 1'b0);
    ce <= 1'b1;
    settle();
    chk(srcPresent, 13'h0008);
    chk(irqOut, 1'b1);
    raiseCmd <= 13'h0000;
    settle();
    wb(1'b0, 8'h24, 16'h0000);
    chk(q, 16'h0008);
    settle();
    chk(irqOut, 1'b0);
    $display("clock enable done");
  endtask : test_freeze

  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  initial begin
    rst = 1'b1;
    ce = 1'b1;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 8'h00;
    dat = 32'h00000000;
    raiseCmd = 13'h0000;
    num_errors = 0;
    num_checks = 0;
    repeat (6) @(posedge core_clk);
    rst <= 1'b0;
    test_reset();
    test_map();
    // A second reset in mid-run must bring back every reset value
    @(posedge core_clk);
    rst <= 1'b1;
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    test_reset();
    test_src();
    test_freeze();
    summarize();
  end
endmodule : iep_irq_enable_priority_bank_test

/* File: iep_pkg.sv */
package iep_pkg;
  typedef logic [15:0] iep_word_t;
  typedef logic [2:0]  iep_prio_t;
  typedef logic [3:0]  iep_idx_t;
endpackage : iep_pkg

/* File: iep_src_model.sv */
`timescale 1ns/100ps
module iep_src_model (
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic [12:0] raiseCmd,
  output logic      [12:0] srcReq
);
  // Peripherals hold a request as a level; reset drops every request
  always_ff @(posedge core_clk) begin
    if (rst) begin
      srcReq <= 13'h0000;
    end else begin
      srcReq <= raiseCmd;
    end
  end
endmodule : iep_src_model
